// *** hdl/bdms_pkg.sv ***
`default_nettype none
package bdms_pkg;

  // ****************************************
  // address map
  // ****************************************
  localparam logic [7:0] CORE_STATUS_OFFSET = 8'h03;
  localparam logic [7:0] CORE_STATUS_MIRROR = 8'h83;
  localparam logic [6:0] INDIRECT_LOCAL = 7'h00;
  localparam logic [6:0] STATUS_LOCAL = 7'h03;
  localparam logic [6:0] POINTER_LOCAL = 7'h04;
  localparam logic [6:0] GPR_FIRST = 7'h20;
  localparam logic [6:0] BANK1_GPR_LAST = 7'h3F;
  localparam logic [6:0] BANK_LAST = 7'h7F;
  localparam logic [6:0] BANK0_GPR_WORDS = 7'h60;
  localparam int RAM_DEPTH = 128;
  localparam int RAM_ADDR_W = 7;
  localparam logic [1:0] BANK0 = 2'h0;
  localparam logic [1:0] BANK1 = 2'h1;

  // ****************************************
  // status fields and reset values
  // ****************************************
  localparam int INDIRECT_BANK_BIT = 7;
  localparam int DIRECT_BANK_HIGH_BIT = 6;
  localparam int DIRECT_BANK_LOW_BIT = 5;
  localparam int TIMEOUT_BIT = 4;
  localparam int POWERDOWN_BIT = 3;
  localparam int ZERO_BIT = 2;
  localparam int NIBBLE_CARRY_BIT = 1;
  localparam int CARRY_BIT = 0;
  localparam logic [7:0] STATUS_RESET = 8'h18;
  localparam logic [7:0] POINTER_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    ALU_ADD = 3'h1,
    ALU_SUB = 3'h2,
    ALU_LOGIC = 3'h4
  } bdms_aluop_t;

  typedef enum logic [4:0] {
    TGT_NONE = 5'h01,
    TGT_STATUS = 5'h02,
    TGT_POINTER = 5'h04,
    TGT_SFR = 5'h08,
    TGT_RAM = 5'h10
  } bdms_kind_t;

  typedef struct packed {
    logic valid;
    logic indirect;
    logic [6:0] addr;
    logic write;
    logic [7:0] wdata;
  } bdms_access_t;

  typedef struct packed {
    logic valid;
    bdms_aluop_t op;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] logicResult;
  } bdms_alu_t;

  typedef struct packed {
    logic watchdogClear;
    logic sleep;
    logic watchdogTimeout;
  } bdms_event_t;

  typedef struct packed {
    logic sel;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bdms_sfr_t;

  typedef struct packed {
    bdms_kind_t kind;
    logic [RAM_ADDR_W-1:0] ramIndex;
    logic [7:0] sfrAddr;
  } bdms_target_t;

  typedef struct packed {
    logic [2:0] mask;
    logic [2:0] value;
  } bdms_flags_t;

endpackage : bdms_pkg
`default_nettype wire

// *** hdl/bdms_ram.sv ***
`timescale 1ns/1ps
`default_nettype none
module bdms_ram import bdms_pkg::*; (
  input wire logic clk,
  input wire logic writeEn,
  input wire logic readEn,
  input wire logic [RAM_ADDR_W-1:0] index,
  input wire logic [7:0] writeData,
  output logic [7:0] readData
);

  // ****************************************
  // general purpose static ram
  // ****************************************
  logic [7:0] cells [RAM_DEPTH];

  always_ff @(posedge clk) begin
    if (writeEn) begin
      cells[index] <= writeData;
    end
    if (readEn) begin
      readData <= cells[index];
    end
  end

endmodule : bdms_ram
`default_nettype wire

// *** hdl/bdms_core.sv ***
// Behaviour
// - status bits 6:5 pick direct bank; 00 bank 0, 01 bank 1, others absent
// - each bank is 128 bytes: low special registers, static ram above (bank 1 ram only 20h-3Fh, 40h up absent)
// - one status register answers at 03h and at 83h
// - indirect-data location 00h/80h reaches the location the pointer selects
// - flag-affecting instruction writing status leaves low three bits to alu
// - time-out and power-down flags ignore every instruction write
// - clearing status clears bank bits and sets zero, other flags kept
// - status bit 7 picks indirect bank pair; upper pair not implemented here
// - in subtraction carry and nibble carry mean no borrow
// - time-out flag set by power-up, watchdog clear, sleep; cleared by time-out
// - nibble carry set on carry out of bit 3 on add or subtract
`timescale 1ns/1ps
`default_nettype none
module bdms_core import bdms_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire bdms_access_t access,
  input wire bdms_alu_t alu,
  input wire bdms_event_t hwEvent,
  output bdms_sfr_t sfrReq,
  input wire logic [7:0] sfrReadData,
  output logic [7:0] readData,
  output logic [7:0] coreStatus
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] pointer;
    logic [7:0] localData;
    logic fromRam;
  } bdms_state_t;

  bdms_state_t st;
  bdms_state_t next_st;
  logic [1:0] rstPipe;
  logic rstSyncN;
  bdms_target_t target;
  bdms_flags_t flags;
  logic ramWrite;
  logic ramRead;
  logic [7:0] ramData;

  // ****************************************
  // reset release
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end

  assign rstSyncN = rstPipe[1];

  // ****************************************
  // address decode
  // ****************************************
  function automatic bdms_target_t bdms_decode(
    input logic indirect,
    input logic [6:0] addr,
    input logic [7:0] status,
    input logic [7:0] pointer
  );
    bdms_target_t t;
    logic [8:0] full;
    logic [1:0] bank;
    logic [6:0] inBank;
    logic viaPointer;
    t.kind = TGT_NONE;
    t.ramIndex = '0;
    t.sfrAddr = 8'h00;
    viaPointer = indirect || (addr == INDIRECT_LOCAL);
    if (viaPointer) begin
      full = {status[INDIRECT_BANK_BIT], pointer};
    end else begin
      full = {status[DIRECT_BANK_HIGH_BIT], status[DIRECT_BANK_LOW_BIT], addr};
    end
    bank = full[8:7];
    inBank = full[6:0];
    if (bank == BANK0 || bank == BANK1) begin
      if (inBank == INDIRECT_LOCAL) begin
        t.kind = TGT_NONE;
      end else if (inBank == STATUS_LOCAL) begin
        t.kind = TGT_STATUS;
      end else if (inBank == POINTER_LOCAL) begin
        t.kind = TGT_POINTER;
      end else if (inBank < GPR_FIRST) begin
        t.kind = TGT_SFR;
        t.sfrAddr = full[7:0];
      end else if (bank == BANK0) begin
        t.kind = TGT_RAM;
        t.ramIndex = inBank - GPR_FIRST;
      end else if (inBank <= BANK1_GPR_LAST) begin
        t.kind = TGT_RAM;
        t.ramIndex = BANK0_GPR_WORDS + (inBank - GPR_FIRST);
      end
    end
    return t;
  endfunction : bdms_decode

  // ****************************************
  // alu flag generation
  // ****************************************
  function automatic bdms_flags_t bdms_alu_flags(input bdms_alu_t op);
    bdms_flags_t f;
    logic [8:0] wide;
    logic [4:0] nibble;
    logic [7:0] result;
    f.mask = 3'h0;
    f.value = 3'h0;
    wide = 9'h000;
    nibble = 5'h00;
    result = 8'h00;
    unique case (op.op)
      ALU_ADD: begin
        wide = {1'b0, op.a} + {1'b0, op.b};
        nibble = {1'b0, op.a[3:0]} + {1'b0, op.b[3:0]};
        result = wide[7:0];
        f.mask = 3'h7;
        f.value[CARRY_BIT] = wide[8];
        f.value[NIBBLE_CARRY_BIT] = nibble[4];
      end
      ALU_SUB: begin
        wide = {1'b0, op.a} + {1'b0, ~op.b} + 9'h001;
        nibble = {1'b0, op.a[3:0]} + {1'b0, ~op.b[3:0]} + 5'h01;
        result = wide[7:0];
        f.mask = 3'h7;
        f.value[CARRY_BIT] = wide[8];
        f.value[NIBBLE_CARRY_BIT] = nibble[4];
      end
      ALU_LOGIC: begin
        result = op.logicResult;
        f.mask = 3'h4;
      end
      default: begin
        f.mask = 3'h0;
      end
    endcase
    f.value[ZERO_BIT] = (result == 8'h00);
    return f;
  endfunction : bdms_alu_flags

  // ****************************************
  // instruction write to status
  // ****************************************
  function automatic logic [7:0] bdms_status_write(
    input logic [7:0] status,
    input logic [7:0] wdata,
    input logic aluValid
  );
    logic [7:0] s;
    s = status;
    s[INDIRECT_BANK_BIT] = wdata[INDIRECT_BANK_BIT];
    s[DIRECT_BANK_HIGH_BIT] = wdata[DIRECT_BANK_HIGH_BIT];
    s[DIRECT_BANK_LOW_BIT] = wdata[DIRECT_BANK_LOW_BIT];
    if (!aluValid) begin
      s[ZERO_BIT] = wdata[ZERO_BIT];
      s[NIBBLE_CARRY_BIT] = wdata[NIBBLE_CARRY_BIT];
      s[CARRY_BIT] = wdata[CARRY_BIT];
    end
    s[TIMEOUT_BIT] = status[TIMEOUT_BIT];
    s[POWERDOWN_BIT] = status[POWERDOWN_BIT];
    return s;
  endfunction : bdms_status_write

  // ****************************************
  // alu flag merge
  // ****************************************
  function automatic logic [7:0] bdms_merge_flags(
    input logic [7:0] status,
    input bdms_flags_t f
  );
    logic [7:0] s;
    s = status;
    for (int i = 0; i < 3; i++) begin
      if (f.mask[i]) begin
        s[i] = f.value[i];
      end
    end
    return s;
  endfunction : bdms_merge_flags

  // ****************************************
  // hardware event flags
  // ****************************************
  function automatic logic [7:0] bdms_apply_events(
    input logic [7:0] status,
    input bdms_event_t ev
  );
    logic [7:0] s;
    s = status;
    if (ev.watchdogClear) begin
      s[TIMEOUT_BIT] = 1'b1;
      s[POWERDOWN_BIT] = 1'b1;
    end
    if (ev.sleep) begin
      s[TIMEOUT_BIT] = 1'b1;
      s[POWERDOWN_BIT] = 1'b0;
    end
    if (ev.watchdogTimeout) begin
      s[TIMEOUT_BIT] = 1'b0;
    end
    return s;
  endfunction : bdms_apply_events

  // ****************************************
  // local read data select
  // ****************************************
  function automatic logic [7:0] bdms_read_local(
    input bdms_kind_t kind,
    input logic [7:0] status,
    input logic [7:0] pointer,
    input logic [7:0] sfrData,
    input logic [7:0] held
  );
    logic [7:0] d;
    d = READ_ZERO;
    unique case (kind)
      TGT_STATUS: d = status;
      TGT_POINTER: d = pointer;
      TGT_SFR: d = sfrData;
      TGT_RAM: d = held;
      TGT_NONE: d = READ_ZERO;
      default: d = READ_ZERO;
    endcase
    return d;
  endfunction : bdms_read_local

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_st = st;
    target = bdms_decode(access.indirect, access.addr, st.status, st.pointer);
    flags = bdms_alu_flags(alu);
    ramWrite = access.valid && access.write && (target.kind == TGT_RAM);
    ramRead = access.valid && !access.write && (target.kind == TGT_RAM);
    if (access.valid && !access.write) begin
      next_st.fromRam = (target.kind == TGT_RAM);
      next_st.localData = bdms_read_local(target.kind, st.status, st.pointer, sfrReadData,
        st.localData);
    end
    if (access.valid && access.write) begin
      if (target.kind == TGT_STATUS) begin
        next_st.status = bdms_status_write(st.status, access.wdata, alu.valid);
      end else if (target.kind == TGT_POINTER) begin
        next_st.pointer = access.wdata;
      end
    end
    if (alu.valid) begin
      next_st.status = bdms_merge_flags(next_st.status, flags);
    end
    next_st.status = bdms_apply_events(next_st.status, hwEvent);
  end

  // ****************************************
  // special register request
  // ****************************************
  always_comb begin
    sfrReq.sel = access.valid && (target.kind == TGT_SFR);
    sfrReq.write = access.valid && access.write && (target.kind == TGT_SFR);
    sfrReq.addr = target.sfrAddr;
    sfrReq.wdata = access.wdata;
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      st.status <= STATUS_RESET;
      st.pointer <= POINTER_RESET;
      st.localData <= READ_ZERO;
      st.fromRam <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // ram and read data
  // ****************************************
  bdms_ram bdms_ram_inst (
    .clk(clk),
    .writeEn(ramWrite),
    .readEn(ramRead),
    .index(target.ramIndex),
    .writeData(access.wdata),
    .readData(ramData)
  );

  assign readData = st.fromRam ? ramData : st.localData;
  assign coreStatus = st.status;

endmodule : bdms_core
`default_nettype wire

// *** bench/bdms_core_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module bdms_core_monitor import bdms_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire bdms_access_t access,
  input wire bdms_alu_t alu,
  input wire bdms_event_t hwEvent,
  input wire bdms_sfr_t sfrReq,
  input wire logic [7:0] sfrReadData,
  input wire logic [7:0] readData,
  input wire logic [7:0] coreStatus
);
  logic [8:0] sum;
  logic [2:0] addF, subF;
  logic stWr, stRd, quiet, clrOp;
  assign sum = {1'b0, alu.a} + {1'b0, alu.b};
  assign addF = {sum[7:0] == 8'h00, {1'b0, alu.a[3:0]} + alu.b[3:0] > 5'h0F, sum[8]};
  assign subF = {alu.a == alu.b, alu.a[3:0] >= alu.b[3:0], alu.a >= alu.b};
  assign stWr = access.valid && access.write && !access.indirect && access.addr == STATUS_LOCAL;
  assign stRd = access.valid && !access.write && !access.indirect && access.addr == STATUS_LOCAL;
  assign quiet = hwEvent == 3'h0;
  assign clrOp = alu.valid && alu.op == ALU_LOGIC && alu.logicResult == 8'h00;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_TO_PD_HOLD: assert property (stWr && quiet |=> $stable(coreStatus[4:3]))
    else $error("time-out or power-down written");
  AST_STATUS_WRITE: assert property (stWr && quiet && !alu.valid && !coreStatus[6]
    |=> coreStatus == ($past(access.wdata) & 8'hE7 | $past(coreStatus) & 8'h18))
    else $error("status write lost");
  AST_ADD_FLAGS: assert property (alu.valid && alu.op == ALU_ADD
    |=> coreStatus[2:0] == $past(addF)) else $error("add flags wrong");
  AST_SUB_FLAGS: assert property (alu.valid && alu.op == ALU_SUB
    |=> coreStatus[2:0] == $past(subF)) else $error("sub flags wrong");
  AST_CLEAR: assert property (stWr && access.wdata == 8'h00 && clrOp && quiet
    && !coreStatus[6]
    |=> coreStatus == {3'h0, $past(coreStatus[4:3]), 1'b1, $past(coreStatus[1:0])})
    else $error("clear of status wrong");
  AST_SLEEP: assert property (hwEvent.sleep && !hwEvent.watchdogTimeout
    |=> coreStatus[4:3] == 2'h2) else $error("sleep flags wrong");
  AST_TIMEOUT: assert property (hwEvent.watchdogTimeout |=> !coreStatus[4])
    else $error("time-out flag not cleared");
  AST_STATUS_READ: assert property (stRd && !coreStatus[6] |=> readData == $past(coreStatus))
    else $error("status read wrong");
  AST_SFR_READ: assert property (access.valid && !access.write && sfrReq.sel
    |=> readData == $past(sfrReadData)) else $error("sfr read wrong");
  AST_SFR_REQUEST: assert property (access.valid && !access.indirect
    && !coreStatus[6] && access.addr > 7'h04 && access.addr < GPR_FIRST
    |-> sfrReq.sel && sfrReq.write == access.write && sfrReq.wdata == access.wdata
    && sfrReq.addr == {coreStatus[5], access.addr}) else $error("sfr request wrong");
endmodule : bdms_core_monitor
bind bdms_core bdms_core_monitor bdms_core_monitor_inst (.clk, .rst_n, .access, .alu,
  .hwEvent, .sfrReq, .sfrReadData, .readData, .coreStatus);
`default_nettype wire

// *** bench/bdms_sfr_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module bdms_sfr_model import bdms_pkg::*; (
  input wire logic clk,
  input wire bdms_sfr_t sfrReq,
  output logic [7:0] sfrReadData
);
  logic [7:0] regs [256];
  initial begin
    for (int i = 0; i < 256; i++) regs[i] = 8'h5A ^ 8'(i);
  end
  always @(posedge clk) begin
    if (sfrReq.sel && sfrReq.write) regs[sfrReq.addr] <= sfrReq.wdata;
  end
  // unselected: inverse so stale data never looks valid
  assign sfrReadData = sfrReq.sel ? regs[sfrReq.addr] : ~regs[sfrReq.addr];
endmodule : bdms_sfr_model
`default_nettype wire

// *** bench/test_banked_data_memory_status.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_banked_data_memory_status import bdms_pkg::*;;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  bdms_access_t access = '0;
  bdms_alu_t alu = '0;
  bdms_event_t hwEvent = '0;
  bdms_sfr_t sfrReq;
  logic [7:0] sfrReadData, readData, coreStatus;
  logic [1:0] p;
  int err_total = 0;
  int samples_checked = 0;
  bdms_alu_t ops [8] = '{{1'b1, ALU_ADD, 8'h0F, 8'h01, 8'h00}, {1'b1, ALU_ADD, 8'hFF, 8'h01, 8'h00},
    {1'b1, ALU_SUB, 8'h05, 8'h03, 8'h00}, {1'b1, ALU_SUB, 8'h03, 8'h05, 8'h00},
    {1'b1, ALU_SUB, 8'h07, 8'h07, 8'h00}, {1'b1, ALU_SUB, 8'h10, 8'h01, 8'h00},
    {1'b1, ALU_LOGIC, 8'h00, 8'h00, 8'h00}, {1'b1, ALU_LOGIC, 8'h00, 8'h00, 8'h5A}};
  bdms_event_t evs [5] = '{3'h2, 3'h4, 3'h1, 3'h3, 3'h4};
  logic [1:0] evExp [5] = '{2'h2, 2'h3, 2'h1, 2'h0, 2'h3};
  always #50 clk = ~clk;
  bdms_core bdms_core_inst (.clk, .rst_n, .access, .alu, .hwEvent, .sfrReq, .sfrReadData,
    .readData, .coreStatus);
  bdms_sfr_model bdms_sfr_model_inst (.clk, .sfrReq, .sfrReadData);
  // ********
  // helpers
  // ********
  function automatic logic [2:0] fl(bdms_alu_t u, logic [1:0] q);
    logic [8:0] s;
    s = {1'b0, u.a} + {1'b0, u.b};
    if (u.op == ALU_SUB) return {u.a == u.b, u.a[3:0] >= u.b[3:0], u.a >= u.b};
    if (u.op == ALU_LOGIC) return {u.logicResult == 8'h00, q};
    return {s[7:0] == 8'h00, {1'b0, u.a[3:0]} + u.b[3:0] > 5'h0F, s[8]};
  endfunction : fl
  task automatic check(input logic [7:0] seen, input logic [7:0] expv);
    samples_checked++;
    if (seen !== expv) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, expv);
    end
  endtask : check
  task automatic cyc(input bdms_access_t a, input bdms_alu_t u = '0, input bdms_event_t e = '0);
    @(posedge clk);
    access <= a;
    alu <= u;
    hwEvent <= e;
    @(posedge clk);
    access <= '0;
    alu <= '0;
    hwEvent <= '0;
    #1;
  endtask : cyc
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    cyc({1'b1, 1'b0, a, 1'b1, d});
  endtask : wr
  task automatic rd(input logic ind, input logic [6:0] a, input logic [7:0] expv);
    cyc({1'b1, ind, a, 1'b0, 8'h00});
    check(readData, expv);
  endtask : rd
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    stop_test();
  end
  // ********
  // tests
  // ********
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check(coreStatus, STATUS_RESET);
    wr(7'h20, 8'h5A);
    rd(1'b0, 7'h20, 8'h5A);
    wr(7'h03, 8'h20);
    check(coreStatus, 8'h38);
    wr(7'h20, 8'hC3);
    rd(1'b0, 7'h20, 8'hC3);
    rd(1'b0, 7'h40, 8'h00);
    rd(1'b0, 7'h03, 8'h38);
    rd(1'b0, 7'h05, 8'hDF);
    wr(7'h04, 8'hA0);
    rd(1'b0, 7'h04, 8'hA0);
    wr(7'h03, 8'h00);
    check(coreStatus, 8'h18);
    rd(1'b1, 7'h00, 8'hC3);
    rd(1'b0, 7'h00, 8'hC3);
    wr(7'h03, 8'h80);
    rd(1'b1, 7'h00, 8'h00);
    wr(7'h03, 8'h07);
    check(coreStatus, 8'h1F);
    wr(7'h03, 8'h23);
    cyc({1'b1, 1'b0, 7'h03, 1'b1, 8'h00}, ops[6]);
    check(coreStatus, 8'h1F);
    cyc({1'b1, 1'b0, 7'h03, 1'b1, 8'h20}, {1'b1, ALU_ADD, 8'h01, 8'h01, 8'h00});
    check(coreStatus, 8'h38);
    wr(7'h03, 8'h00);
    foreach (ops[i]) begin
      p = coreStatus[1:0];
      cyc('0, ops[i]);
      check(coreStatus, {5'h03, fl(ops[i], p)});
    end
    foreach (evs[i]) begin
      cyc('0, '0, evs[i]);
      check({6'h00, coreStatus[4:3]}, {6'h00, evExp[i]});
    end
    wr(7'h05, 8'h3C);
    rd(1'b0, 7'h05, 8'h3C);
    wr(7'h03, 8'h40);
    rd(1'b0, 7'h20, 8'h00);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check(coreStatus, STATUS_RESET);
    stop_test();
  end
endmodule : test_banked_data_memory_status
`default_nettype wire
